// File: rtl/counter_unit_pkg.sv
package counter_unit_pkg;

	localparam int DATA_WIDTH  = 8;
	localparam int ADDR_WIDTH  = 8;
	localparam int COUNT_WIDTH = 16;

	localparam logic [7:0] ADDR_SHARED_PORT = 8'h06;
	localparam logic [7:0] ADDR_PIN_DATA    = 8'h07;
	localparam logic [7:0] ADDR_IRQ_FLAG    = 8'h0C;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'h0E;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h0F;
	localparam logic [7:0] ADDR_CONTROL     = 8'h10;
	localparam logic [7:0] ADDR_SHARED_DIR  = 8'h86;
	localparam logic [7:0] ADDR_PIN_DIR     = 8'h87;
	localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h8C;

	localparam int CTL_RUN_BIT  = 0;
	localparam int CTL_SRC_BIT  = 1;
	localparam int CTL_OSC_BIT  = 3;
	localparam logic [7:0] CONTROL_MASK = 8'h3F;

	localparam int PIN_CLK_BIT  = 0;
	localparam int PIN_AUX_BIT  = 2;
	localparam int PORT_ONE_BIT = 1;
	localparam int PORT_TWO_BIT = 2;
	localparam int OVF_BIT      = 0;

	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic       PIN_DIR_RESET  = 1'b1;
	localparam logic       PIN_DATA_RESET = 1'b0;
	localparam logic [1:0] PORT_DIR_RESET = 2'h3;
	localparam logic [1:0] PORT_LAT_RESET = 2'h0;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_LAST    = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE     = 16'h0001;

	localparam int FOSC_DIVIDE = 4;
	localparam logic [1:0] DIV_LAST = 2'(FOSC_DIVIDE - 1);
	localparam logic [1:0] DIV_ONE  = 2'h1;
	localparam logic [1:0] DIV_RESET = 2'h0;

	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'b00,
		SRC_EXTERNAL = 2'b01,
		SRC_FIRMWARE = 2'b10,
		SRC_CRYSTAL  = 2'b11
	} clk_src_e;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset.
	input  wire logic clock,
	input  wire logic rst_n,
	// Level from outside the clock domain and its safe copy.
	input  wire logic async_in,
	output logic      sync_out
);
	logic first_stage;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			first_stage <= 1'b0;
			sync_out    <= 1'b0;
		end else begin
			first_stage <= async_in;
			sync_out    <= first_stage;
		end
	end
endmodule

// File: rtl/counter_unit.sv
// Contract
// - Run, crystal and source bits clear: counter idle, both pins plain I/O.
// - Timer mode counts the system clock divided by four; pins stay plain I/O unless crystal enable is set.
// - The run bit starts and stops the counter in every mode.
// - External mode counts rising edges of the clock input pin.
// - External mode: reading the pin data bit returns the clock pin level.
// - Firmware mode: pin data bit drives the pin and clocks the counter.
// - Counter modes: port read of clock pin set as input returns zero.
// - Counter modes: clock pin as output reads latch; writes reach latch only.
// - Clearing source select with crystal enable clear drives the clock pin from its latch again.
// - Crystal enable plus external select: pins form oscillator clocking counter.
// - Crystal mode: pin data bit reads zero; writes never reach the pin.
// - Crystal mode: both port pins read zero when set as inputs.
// - Crystal mode: output pins read latches; writes touch only latches.
// - Source select and crystal enable clear: both pins driven from latches.
// - Control bit 3 enables the crystal oscillator.
// - The crystal oscillator keeps running during sleep.
// - Sixteen-bit count runs 0000h to FFFFh, then rolls over to 0000h.
// - Rollover sets the overflow flag, bit 0 of the flag register.
// - Interrupt request only when overflow enable, bit 0, is set.
// - Crystal enable clear powers down the oscillator amplifier.
`timescale 1ns/1ps
module counter_unit
	import counter_unit_pkg::*;
(
	// Clock and reset.
	input  wire logic                                 clock,
	input  wire logic                                 rst_n,
	// Register port.
	input  wire logic [counter_unit_pkg::ADDR_WIDTH-1:0] addr,
	input  wire logic [counter_unit_pkg::DATA_WIDTH-1:0] wdata,
	input  wire logic                                 wr,
	input  wire logic                                 rd,
	output logic      [counter_unit_pkg::DATA_WIDTH-1:0] rdata,
	// Shared pin one: clock input, crystal amplifier output.
	input  wire logic                                 shared_pin_one_in,
	output logic                                      shared_pin_one_out,
	output logic                                      shared_pin_one_oe,
	// Shared pin two: crystal input.
	input  wire logic                                 shared_pin_two_in,
	output logic                                      shared_pin_two_out,
	output logic                                      shared_pin_two_oe,
	// Power state, oscillator control and interrupt.
	input  wire logic                                 sleep,
	output logic                                      crystal_amp_enable,
	output logic                                      overflow_irq
);
	import counter_unit_pkg::*;

	// Port bit read: a pin taken by the counter reads zero as input.
	function automatic logic port_bit(input logic taken, input logic is_input,
			input logic latch, input logic pin);
		logic value;
		value = latch;
		if (is_input) begin
			value = taken ? 1'b0 : pin;
		end
		return value;
	endfunction

	logic [7:0]  counter_control_reg;
	logic [15:0] sixteen_bit_counter;
	logic        overflow_flag;
	logic        overflow_irq_enable;
	logic        clock_pin_data_bit;
	logic        clock_pin_dir;
	logic        aux_pin_data;
	logic        aux_pin_dir;
	logic [1:0]  port_latch;
	logic [1:0]  port_dir;
	logic [1:0]  div_count;
	logic        src_prev;
	logic [1:0]  pin_sync_level;
	logic [7:0]  next_rdata;
	logic [15:0] next_count;

	// Both pins pass a two-stage synchroniser before any logic reads them.
	wire [1:0] pin_raw = {shared_pin_two_in, shared_pin_one_in};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			pin_sync u_sync (
				.clock    (clock),
				.rst_n    (rst_n),
				.async_in (pin_raw[gi]),
				.sync_out (pin_sync_level[gi])
			);
		end
	endgenerate

	wire counter_run_bit     = counter_control_reg[CTL_RUN_BIT];
	wire clock_source_select = counter_control_reg[CTL_SRC_BIT];
	wire crystal_osc_enable  = counter_control_reg[CTL_OSC_BIT];

	wire wr_control   = wr && (addr == ADDR_CONTROL);
	wire wr_count_low = wr && (addr == ADDR_COUNT_LOW);
	wire wr_count_hi  = wr && (addr == ADDR_COUNT_HIGH);
	wire wr_flag      = wr && (addr == ADDR_IRQ_FLAG);
	wire wr_enable    = wr && (addr == ADDR_IRQ_ENABLE);
	wire wr_pin_data  = wr && (addr == ADDR_PIN_DATA);
	wire wr_pin_dir   = wr && (addr == ADDR_PIN_DIR);
	wire wr_port      = wr && (addr == ADDR_SHARED_PORT);
	wire wr_port_dir  = wr && (addr == ADDR_SHARED_DIR);
	wire wr_count     = wr_count_low || wr_count_hi;

	// Source choice from the control bits and the clock pin direction.
	clk_src_e source;
	assign source = (crystal_osc_enable && clock_source_select) ? SRC_CRYSTAL :
		clock_source_select ? (clock_pin_dir ? SRC_EXTERNAL : SRC_FIRMWARE) :
		SRC_INTERNAL;

	// Pin one belongs to the counter in any counter mode, pin two to the
	// oscillator only.
	wire pin_one_taken = clock_source_select || crystal_osc_enable;
	wire pin_two_taken = crystal_osc_enable;

	// System clock divided by four; it stops with the main clock in sleep.
	wire fosc_tick = !sleep && (div_count == DIV_LAST);

	logic src_level;
	always_comb begin
		case (source)
			SRC_EXTERNAL: src_level = pin_sync_level[0];
			SRC_FIRMWARE: src_level = clock_pin_data_bit;
			SRC_CRYSTAL:  src_level = pin_sync_level[0];
			default:      src_level = 1'b0;
		endcase
	end

	wire src_rise = src_level && !src_prev;
	wire tick = counter_run_bit &&
		((source == SRC_INTERNAL) ? fosc_tick : src_rise);
	// A byte write outranks a count in the same cycle.
	wire rollover = tick && !wr_count &&
		(sixteen_bit_counter == COUNT_LAST);

	always_comb begin
		next_count = sixteen_bit_counter;
		if (wr_count_low) begin
			next_count = {sixteen_bit_counter[15:8], wdata};
		end else if (wr_count_hi) begin
			next_count = {wdata, sixteen_bit_counter[7:0]};
		end else if (tick) begin
			next_count = sixteen_bit_counter + COUNT_ONE;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_count <= DIV_RESET;
		end else if (!sleep) begin
			div_count <= div_count + DIV_ONE;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			src_prev            <= 1'b0;
			sixteen_bit_counter <= COUNT_RESET;
		end else begin
			src_prev            <= src_level;
			sixteen_bit_counter <= next_count;
		end
	end

	// Overflow flag: a rollover wins over a clearing write.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			overflow_flag <= 1'b0;
		end else if (rollover) begin
			overflow_flag <= 1'b1;
		end else if (wr_flag) begin
			overflow_flag <= wdata[OVF_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			overflow_irq_enable <= 1'b0;
			counter_control_reg <= CONTROL_RESET;
		end else begin
			if (wr_enable) begin
				overflow_irq_enable <= wdata[OVF_BIT];
			end
			if (wr_control) begin
				counter_control_reg <= wdata & CONTROL_MASK;
			end
		end
	end

	// Latches always store; whether a latch reaches a pin is decided below.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			clock_pin_data_bit <= PIN_DATA_RESET;
			aux_pin_data       <= PIN_DATA_RESET;
			clock_pin_dir      <= PIN_DIR_RESET;
			aux_pin_dir        <= PIN_DIR_RESET;
		end else begin
			if (wr_pin_data) begin
				clock_pin_data_bit <= wdata[PIN_CLK_BIT];
				aux_pin_data       <= wdata[PIN_AUX_BIT];
			end
			if (wr_pin_dir) begin
				clock_pin_dir <= wdata[PIN_CLK_BIT];
				aux_pin_dir   <= wdata[PIN_AUX_BIT];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port_latch <= PORT_LAT_RESET;
			port_dir   <= PORT_DIR_RESET;
		end else begin
			if (wr_port) begin
				port_latch <= wdata[PORT_TWO_BIT:PORT_ONE_BIT];
			end
			if (wr_port_dir) begin
				port_dir <= wdata[PORT_TWO_BIT:PORT_ONE_BIT];
			end
		end
	end

	// Pin drivers.
	wire fw_drive = (source == SRC_FIRMWARE);
	assign shared_pin_one_oe  = pin_one_taken ? fw_drive : !port_dir[0];
	assign shared_pin_one_out = fw_drive ? clock_pin_data_bit :
		port_latch[0];
	assign shared_pin_two_oe  = pin_two_taken ? 1'b0 : !port_dir[1];
	assign shared_pin_two_out = port_latch[1];

	// The amplifier follows the enable alone, so sleep never stops it.
	assign crystal_amp_enable = crystal_osc_enable;
	assign overflow_irq = overflow_flag && overflow_irq_enable;

	// Read views.
	wire pin_data_read = (source == SRC_CRYSTAL) ? 1'b0 :
		(source == SRC_EXTERNAL) ? pin_sync_level[0] :
		clock_pin_data_bit;
	wire port_one_read = port_bit(pin_one_taken, port_dir[0], port_latch[0],
		pin_sync_level[0]);
	wire port_two_read = port_bit(pin_two_taken, port_dir[1], port_latch[1],
		pin_sync_level[1]);

	always_comb begin
		next_rdata = 8'h00;
		case (addr)
			ADDR_SHARED_PORT: begin
				next_rdata[PORT_ONE_BIT] = port_one_read;
				next_rdata[PORT_TWO_BIT] = port_two_read;
			end
			ADDR_SHARED_DIR: begin
				next_rdata[PORT_TWO_BIT:PORT_ONE_BIT] = port_dir;
			end
			ADDR_PIN_DATA: begin
				next_rdata[PIN_CLK_BIT] = pin_data_read;
				next_rdata[PIN_AUX_BIT] = aux_pin_data;
			end
			ADDR_PIN_DIR: begin
				next_rdata[PIN_CLK_BIT] = clock_pin_dir;
				next_rdata[PIN_AUX_BIT] = aux_pin_dir;
			end
			ADDR_IRQ_FLAG:   next_rdata[OVF_BIT] = overflow_flag;
			ADDR_IRQ_ENABLE: next_rdata[OVF_BIT] = overflow_irq_enable;
			ADDR_COUNT_LOW:  next_rdata = sixteen_bit_counter[7:0];
			ADDR_COUNT_HIGH: next_rdata = sixteen_bit_counter[15:8];
			ADDR_CONTROL:    next_rdata = counter_control_reg;
			default:         next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= 8'h00;
		end
	end

	// Checks.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_quiet_off;
		!counter_run_bit && !wr_count;
	endsequence

	AST_OFF_HOLDS: assert property (
		s_quiet_off |=> (sixteen_bit_counter == $past(sixteen_bit_counter)))
		else $error("counter moved while stopped");

	AST_OFF_PINS: assert property (
		(counter_control_reg[3:0] == 4'h0) |->
			(shared_pin_one_oe == !port_dir[0]) &&
			(shared_pin_two_oe == !port_dir[1]))
		else $error("pins not plain I/O while off");

	AST_DIV_SPACING: assert property (
		fosc_tick |=> !fosc_tick [*3])
		else $error("divided clock faster than one in four");

	AST_TIMER_STEP: assert property (
		(source == SRC_INTERNAL && tick && !wr_count) |->
			fosc_tick ##1
			(sixteen_bit_counter == $past(sixteen_bit_counter) + COUNT_ONE))
		else $error("timer step wrong");

	AST_RUN_GATES: assert property (
		tick && !wr_count |=> !$stable(sixteen_bit_counter))
		else $error("run bit set but counter held");

	sequence s_ext_rise;
		source == SRC_EXTERNAL && counter_run_bit && !wr_count ##0
		src_rise;
	endsequence

	AST_EXT_COUNT: assert property (
		s_ext_rise |=>
			sixteen_bit_counter == $past(sixteen_bit_counter) + COUNT_ONE)
		else $error("external edge not counted");

	AST_EXT_READ: assert property (
		(rd && addr == ADDR_PIN_DATA && source == SRC_EXTERNAL) |=>
			rdata[PIN_CLK_BIT] == $past(pin_sync_level[0]))
		else $error("pin data read not the pin level");

	AST_FW_DRIVE: assert property (
		(source == SRC_FIRMWARE) |->
			shared_pin_one_oe && shared_pin_one_out == clock_pin_data_bit)
		else $error("firmware clock not driven");

	AST_PORT_ONE_ZERO: assert property (
		(rd && addr == ADDR_SHARED_PORT && clock_source_select &&
			port_dir[0]) |=> !rdata[PORT_ONE_BIT])
		else $error("taken clock pin read nonzero");

	AST_PORT_ONE_LATCH: assert property (
		(rd && addr == ADDR_SHARED_PORT && !port_dir[0]) |=>
			rdata[PORT_ONE_BIT] == $past(port_latch[0]))
		else $error("output pin read not the latch");

	AST_CRYSTAL_PINS: assert property (
		(source == SRC_CRYSTAL) |->
			!shared_pin_one_oe && !shared_pin_two_oe && crystal_amp_enable)
		else $error("crystal mode drives a pin");

	AST_CRYSTAL_DATA: assert property (
		(rd && addr == ADDR_PIN_DATA && source == SRC_CRYSTAL) |=>
			!rdata[PIN_CLK_BIT])
		else $error("pin data bit nonzero in crystal mode");

	AST_CRYSTAL_READ: assert property (
		(rd && addr == ADDR_SHARED_PORT && crystal_osc_enable &&
			port_dir == 2'h3) |=> rdata[PORT_TWO_BIT:PORT_ONE_BIT] == 2'h0)
		else $error("crystal pins read nonzero");

	AST_ROLLOVER: assert property (
		rollover |=> (sixteen_bit_counter == COUNT_RESET) && overflow_flag)
		else $error("rollover wrong");

	AST_FLAG_SET_WINS: assert property (
		(rollover && wr_flag && !wdata[OVF_BIT]) |=> overflow_flag)
		else $error("flag clear beat rollover");

	AST_IRQ_GATED: assert property (
		overflow_irq |-> overflow_irq_enable && overflow_flag)
		else $error("interrupt without enable");

endmodule

// File: tb/pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
	// Drive from the block.
	input  wire logic one_out,
	input  wire logic one_oe,
	input  wire logic two_out,
	input  wire logic two_oe,
	// Source control: amplifier enable and external clock level.
	input  wire logic osc_run,
	input  wire logic ext_level,
	// Resolved pin levels.
	output logic      pin_one,
	output logic      pin_two
);
	logic xtal = 1'b0;

	// The crystal swings only while its amplifier is powered, sleep or not.
	always #40 if (osc_run) xtal = ~xtal;

	// Pin two has a pull-up when nobody drives it.
	assign pin_one = one_oe ? one_out : (osc_run ? xtal : ext_level);
	assign pin_two = two_oe ? two_out : (osc_run ? ~xtal : 1'b1);
endmodule

// File: tb/counter_unit_tb.sv
`timescale 1ns/1ps
module counter_unit_tb;
	import counter_unit_pkg::*;
	logic       clock;
	logic       rst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       one_in;
	logic       one_out;
	logic       one_oe;
	logic       two_in;
	logic       two_out;
	logic       two_oe;
	logic       sleep;
	logic       amp;
	logic       irq;
	logic       ext_level;
	logic [7:0] got;
	int         errors;
	int         comparisons;
	int         cnt;

	counter_unit counter_unit_i (
		.clock              (clock),
		.rst_n              (rst_n),
		.addr               (addr),
		.wdata              (wdata),
		.wr                 (wr),
		.rd                 (rd),
		.rdata              (rdata),
		.shared_pin_one_in  (one_in),
		.shared_pin_one_out (one_out),
		.shared_pin_one_oe  (one_oe),
		.shared_pin_two_in  (two_in),
		.shared_pin_two_out (two_out),
		.shared_pin_two_oe  (two_oe),
		.sleep              (sleep),
		.crystal_amp_enable (amp),
		.overflow_irq       (irq)
	);

	pin_partner pin_partner_i (
		.one_out   (one_out),
		.one_oe    (one_oe),
		.two_out   (two_out),
		.two_oe    (two_oe),
		.osc_run   (amp),
		.ext_level (ext_level),
		.pin_one   (one_in),
		.pin_two   (two_in)
	);

	always #2 clock = ~clock;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e,
			input logic [7:0] m = 8'hFF);
		rd_reg(a);
		check(got & m, e);
	endtask

	task automatic set_count(input int v);
		wr_reg(ADDR_COUNT_LOW, 8'(v));
		wr_reg(ADDR_COUNT_HIGH, 8'(v >> 8));
		cnt = v;
	endtask

	task automatic pulse(input int n);
		repeat (n) begin
			ext_level <= 1'b1;
			repeat (6) @(posedge clock);
			ext_level <= 1'b0;
			repeat (6) @(posedge clock);
		end
		#1;
	endtask

	task automatic results();
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		results();
	end

	initial begin
		logic [7:0] v;
		int         n;
		clock = 1'b0;
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		sleep = 1'b0;
		ext_level = 1'b0;
		errors = 0;
		comparisons = 0;
		v = 8'($urandom(74635));
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rc(ADDR_CONTROL, 8'h00);
		rc(ADDR_COUNT_LOW, 8'h00);
		rc(ADDR_COUNT_HIGH, 8'h00);
		rc(ADDR_IRQ_FLAG, 8'h00);
		rc(ADDR_IRQ_ENABLE, 8'h00);
		rc(ADDR_PIN_DIR, 8'h05);
		rc(8'h55, 8'h00);
		wr_reg(ADDR_CONTROL, 8'hC0);
		rc(ADDR_CONTROL, 8'h00);
		check(8'({one_oe, two_oe}), 8'h00);
		v = 8'($urandom) & 8'h06;
		wr_reg(ADDR_SHARED_DIR, 8'h00);
		wr_reg(ADDR_SHARED_PORT, v);
		check(8'({one_oe, two_oe, one_out, two_out}), {6'h03, v[1], v[2]});
		rc(ADDR_SHARED_PORT, v, 8'h06);
		rc(ADDR_COUNT_LOW, 8'h00);
		wr_reg(ADDR_CONTROL, 8'h01);
		check(8'({one_oe, two_oe}), 8'h03);
		repeat (38) @(posedge clock);
		wr_reg(ADDR_CONTROL, 8'h00);
		cnt = 10;
		rc(ADDR_COUNT_LOW, 8'(cnt));
		sleep <= 1'b1;
		wr_reg(ADDR_CONTROL, 8'h01);
		repeat (38) @(posedge clock);
		wr_reg(ADDR_CONTROL, 8'h00);
		sleep <= 1'b0;
		rc(ADDR_COUNT_LOW, 8'(cnt));
		set_count(16'hFFFE);
		wr_reg(ADDR_IRQ_ENABLE, 8'h01);
		wr_reg(ADDR_CONTROL, 8'h01);
		repeat (10) @(posedge clock);
		wr_reg(ADDR_CONTROL, 8'h00);
		cnt = (cnt + 3) % 65536;
		rc(ADDR_COUNT_LOW, 8'(cnt));
		rc(ADDR_COUNT_HIGH, 8'(cnt >> 8));
		rc(ADDR_IRQ_FLAG, 8'h01, 8'h01);
		check(8'(irq), 8'h01);
		wr_reg(ADDR_IRQ_ENABLE, 8'h00);
		check(8'(irq), 8'h00);
		wr_reg(ADDR_IRQ_FLAG, 8'h00);
		rc(ADDR_IRQ_FLAG, 8'h00, 8'h01);
		set_count(0);
		wr_reg(ADDR_SHARED_DIR, 8'h02);
		wr_reg(ADDR_CONTROL, 8'h03);
		check(8'(one_oe), 8'h00);
		n = 1 + $urandom % 8;
		pulse(n);
		cnt += n;
		rc(ADDR_COUNT_LOW, 8'(cnt));
		set_count(16'hFFFF);
		ext_level <= 1'b1;
		cnt = 0;
		@(posedge clock);
		wr_reg(ADDR_IRQ_FLAG, 8'h00);
		rc(ADDR_IRQ_FLAG, 8'h01, 8'h01);
		rc(ADDR_PIN_DATA, 8'h01, 8'h01);
		rc(ADDR_SHARED_PORT, 8'h00, 8'h02);
		ext_level <= 1'b0;
		wr_reg(ADDR_SHARED_DIR, 8'h00);
		wr_reg(ADDR_SHARED_PORT, 8'h02);
		rc(ADDR_SHARED_PORT, 8'h02, 8'h02);
		check(8'(one_oe), 8'h00);
		wr_reg(ADDR_CONTROL, 8'h02);
		pulse(2);
		rc(ADDR_COUNT_LOW, 8'(cnt));
		set_count(0);
		wr_reg(ADDR_PIN_DIR, 8'h04);
		wr_reg(ADDR_CONTROL, 8'h03);
		check(8'(one_oe), 8'h01);
		n = 1 + $urandom % 8;
		repeat (n) begin
			wr_reg(ADDR_PIN_DATA, 8'h01);
			check(8'(one_out), 8'h01);
			repeat (6) @(posedge clock);
			wr_reg(ADDR_PIN_DATA, 8'h00);
			repeat (6) @(posedge clock);
		end
		rc(ADDR_COUNT_LOW, 8'(n));
		wr_reg(ADDR_PIN_DATA, 8'h01);
		rc(ADDR_PIN_DATA, 8'h01, 8'h01);
		wr_reg(ADDR_CONTROL, 8'h00);
		check(8'({one_oe, one_out}), 8'h03);
		wr_reg(ADDR_SHARED_DIR, 8'h06);
		set_count(0);
		sleep <= 1'b1;
		wr_reg(ADDR_CONTROL, 8'h0B);
		check(8'(amp), 8'h01);
		check(8'({one_oe, two_oe}), 8'h00);
		repeat (400) @(posedge clock);
		wr_reg(ADDR_CONTROL, 8'h0A);
		sleep <= 1'b0;
		rd_reg(ADDR_COUNT_LOW);
		check(8'(got != 8'h00), 8'h01);
		wr_reg(ADDR_PIN_DATA, 8'h01);
		rc(ADDR_PIN_DATA, 8'h00, 8'h01);
		check(8'(one_oe), 8'h00);
		rc(ADDR_SHARED_PORT, 8'h00, 8'h06);
		wr_reg(ADDR_SHARED_DIR, 8'h00);
		wr_reg(ADDR_SHARED_PORT, 8'h06);
		rc(ADDR_SHARED_PORT, 8'h06, 8'h06);
		check(8'({one_oe, two_oe}), 8'h00);
		wr_reg(ADDR_CONTROL, 8'h00);
		check(8'({one_oe, two_oe, one_out, two_out}), 8'h0F);
		check(8'(amp), 8'h00);
		results();
	end
endmodule
